//--- dv/bridge_secondary_clock_control_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module bridge_secondary_clock_control_checker (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Bus handshakes
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_rvalid,
    // Clocks and run lines
    input wire logic [4:0] downstream_clock_outputs,
    input wire logic       upstream_clock_run_n_out,
    input wire logic       upstream_clock_run_n_oe,
    input wire logic       downstream_clock_run_n_out,
    input wire logic       downstream_clock_run_n_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // High phases last one cycle, so gating can never cut a runt
    a_clock_high_once: assert property (
        |downstream_clock_outputs |=> downstream_clock_outputs == 5'h00)
        else $error("clock output high for more than one cycle");
    a_reset_state: assert property (disable iff (1'b0)
        !aresetn |=> downstream_clock_outputs == 5'h00 && !s_axi_bvalid && !s_axi_rvalid
        && downstream_clock_run_n_oe && !downstream_clock_run_n_out)
        else $error("outputs wrong under reset");
    a_up_drive_low: assert property (
        upstream_clock_run_n_oe |-> !upstream_clock_run_n_out)
        else $error("upstream run line driven high");
    a_up_pull_len: assert property (
        $rose(upstream_clock_run_n_oe) |-> upstream_clock_run_n_oe [*4] ##1 !upstream_clock_run_n_oe)
        else $error("upstream pull not four cycles");
    a_dn_announce: assert property (
        $rose(downstream_clock_run_n_oe && downstream_clock_run_n_out) |->
        (downstream_clock_run_n_oe && downstream_clock_run_n_out) [*5] ##1 !downstream_clock_run_n_oe)
        else $error("stop announce not five cycles");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write response late");
    a_write_release: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not withdrawn");
    a_read_answer: assert property (
        s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read data late");
endmodule // bridge_secondary_clock_control_checker
bind bridge_secondary_clock_control bridge_secondary_clock_control_checker
    bridge_secondary_clock_control_checker_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rvalid, .downstream_clock_outputs,
    .upstream_clock_run_n_out, .upstream_clock_run_n_oe, .downstream_clock_run_n_out,
    .downstream_clock_run_n_oe);
`default_nettype wire

//--- dv/clk_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host and secondary-bus devices
// ----------------------------------------
module clk_partner (
    // Design side
    input  wire logic [4:0] clk_out,
    input  wire logic       up_out,
    input  wire logic       up_oe,
    input  wire logic       dn_out,
    input  wire logic       dn_oe,
    output wire logic       fb,
    output wire logic       up_level,
    output wire logic       dn_level,
    // Scenario controls
    input  wire logic       host_low,
    input  wire logic       dev_pull,
    input  wire logic       fb_dead
);
    // Output 0 is wired back; a broken trace reads low
    assign fb = clk_out[0] & ~fb_dead;
    // Both run lines have pull-ups, any driver low wins
    assign up_level = ~(host_low | (up_oe & ~up_out));
    assign dn_level = ~(dev_pull | (dn_oe & ~dn_out));
endmodule // clk_partner
`default_nettype wire

//--- dv/test_bridge_secondary_clock_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "bridge_clk_regs.vh"
// ----------------------------------------
// Register-level bench
// ----------------------------------------
module test_bridge_secondary_clock_control;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, downstream_clock_feedback, power_clock_mgmt_strap;
    logic [4:0]  downstream_clock_outputs;
    logic        upstream_clock_run_n_in, upstream_clock_run_n_out, upstream_clock_run_n_oe;
    logic        downstream_clock_run_n_in, downstream_clock_run_n_out, downstream_clock_run_n_oe;
    logic        host_low, dev_pull, fb_dead;
    int          err_total, total_checks;
    bridge_secondary_clock_control bridge_secondary_clock_control_i (.*);
    clk_partner clk_partner_i (.clk_out(downstream_clock_outputs), .up_out(upstream_clock_run_n_out),
        .up_oe(upstream_clock_run_n_oe), .dn_out(downstream_clock_run_n_out),
        .dn_oe(downstream_clock_run_n_oe), .fb(downstream_clock_feedback),
        .up_level(upstream_clock_run_n_in), .dn_level(downstream_clock_run_n_in),
        .host_low(host_low), .dev_pull(dev_pull), .fb_dead(fb_dead));
    // 40 MHz primary clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    function automatic logic [31:0] adr(input logic [7:0] i);
        return {22'h0, i, 2'h0};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bounded wait for a handshake; a hang counts as a mismatch
    // Selector: 0 awready, 1 bvalid, 2 arready, else rvalid
    task automatic hs(input int k);
        int   n = 0;
        logic s;
        do begin
            @(posedge aclk);
            n++;
            case (k)
                0: s = s_axi_awready;
                1: s = s_axi_bvalid;
                2: s = s_axi_arready;
                default: s = s_axi_rvalid;
            endcase
        end while (s !== 1'b1 && n < 100);
        if (s !== 1'b1) chk("handshake", 32'h1, 32'h0);
    endtask
    task automatic wr(input logic [31:0] ad, input logic [31:0] wd, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        hs(0);
        chk("wready", 32'h1, {31'h0, s_axi_wready});
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        hs(1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
    endtask
    task automatic rd(input logic [31:0] ad, output logic [31:0] rv, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        hs(2);
        s_axi_arvalid <= 1'b0;
        hs(3);
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    endtask
    task automatic st(input string nm, input int b, input logic e);
        logic [31:0] v;
        rd(adr(`IDX_CLK_STATUS), v, `AXI_RESP_OKAY);
        chk(nm, {31'h0, e}, {31'h0, v[b]});
    endtask
    // Counts rising edges per output over 40 cycles; a partial count reads as unknown
    task automatic rate(input logic [4:0] e, input int w);
        int         c [5];
        logic [4:0] p, m;
        repeat (w) @(posedge aclk);
        @(negedge aclk);
        p = downstream_clock_outputs;
        repeat (40) begin
            @(negedge aclk);
            for (int i = 0; i < 5; i++) c[i] += downstream_clock_outputs[i] & ~p[i];
            p = downstream_clock_outputs;
        end
        for (int i = 0; i < 5; i++) m[i] = (c[i] == 20) ? 1'b1 : (c[i] == 0) ? 1'b0 : 1'bx;
        chk("clocks", {27'h0, e}, {27'h0, m});
        @(posedge aclk);
    endtask
    task automatic endt(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, err_total);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog, well beyond the expected run
    initial begin
        #400000;
        chk("watchdog", 32'h0, 32'h1);
        final_report;
    end
    // Main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        {power_clock_mgmt_strap, dev_pull, fb_dead} = '0;
        host_low = 1'b1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(adr(`IDX_CLK_DISABLE), d, `AXI_RESP_OKAY);
        chk("disable_rst", {27'h0, `RST_CLK_DISABLE}, d);
        rd(adr(`IDX_CLK_RUN_CTRL), d, `AXI_RESP_OKAY);
        chk("ctrl_rst", {30'h0, `RST_CLK_RUN_CTRL}, d);
        wr(32'h0000_0400, 32'h0000_001F, `AXI_RESP_SLVERR);
        rd(32'h0000_0400, d, `AXI_RESP_SLVERR);
        chk("unmapped", 32'h0, d);
        rate(5'h1F, 4);
        st("fb_alive", `STAT_FB_ALIVE_BIT, 1'b1);
        endt("reset");
        for (int i = 0; i < 5; i++) begin
            wr(adr(`IDX_CLK_DISABLE), 32'h1 << i, `AXI_RESP_OKAY);
            rate(5'h1F & ~(5'h1 << i), 4);
        end
        wr(adr(`IDX_CLK_DISABLE), 32'h0000_0015, `AXI_RESP_OKAY);
        rd(adr(`IDX_CLK_DISABLE), d, `AXI_RESP_OKAY);
        chk("disable_rb", 32'h0000_0015, d);
        // A write with its low byte lane off must leave the disables alone
        s_axi_wstrb <= 4'h0;
        wr(adr(`IDX_CLK_DISABLE), 32'h0000_001F, `AXI_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(adr(`IDX_CLK_DISABLE), d, `AXI_RESP_OKAY);
        chk("strobe_off", 32'h0000_0015, d);
        rate(5'h0A, 4);
        wr(adr(`IDX_CLK_DISABLE), 32'h0, `AXI_RESP_OKAY);
        fb_dead <= 1'b1;
        repeat (30) @(posedge aclk);
        st("fb_dead", `STAT_FB_ALIVE_BIT, 1'b0);
        fb_dead <= 1'b0;
        endt("disable");
        power_clock_mgmt_strap <= 1'b1;
        wr(adr(`IDX_POWER_STATE), {30'h0, `PSTATE_D3HOT}, `AXI_RESP_OKAY);
        rate(5'h00, 4);
        st("b2", `STAT_B2_BIT, 1'b1);
        st("strap", `STAT_STRAP_BIT, 1'b1);
        power_clock_mgmt_strap <= 1'b0;
        rate(5'h1F, 6);
        wr(adr(`IDX_POWER_STATE), 32'h0, `AXI_RESP_OKAY);
        endt("power");
        wr(adr(`IDX_CLK_RUN_CTRL), 32'h0000_0011, `AXI_RESP_OKAY);
        rate(5'h00, 30);
        st("stopped", `STAT_STOPPED_BIT, 1'b1);
        dev_pull <= 1'b1;
        rate(5'h1F, 8);
        dev_pull <= 1'b0;
        host_low <= 1'b0;
        wr(adr(`IDX_CLK_RUN_CTRL), 32'h0000_0010, `AXI_RESP_OKAY);
        rate(5'h1F, 30);
        wr(adr(`IDX_CLK_RUN_CTRL), 32'h0, `AXI_RESP_OKAY);
        rate(5'h00, 30);
        // Stopped: both run lines released and read high through their pull-ups
        st("up_run", `STAT_UP_RUN_BIT, 1'b1);
        st("dn_run", `STAT_DN_RUN_BIT, 1'b1);
        dev_pull <= 1'b1;
        rate(5'h1F, 8);
        dev_pull <= 1'b0;
        host_low <= 1'b1;
        rate(5'h1F, 30);
        endt("clock_run");
        final_report;
    end
endmodule // test_bridge_secondary_clock_control
`default_nettype wire

//--- include/bridge_clk_regs.vh
`ifndef BRIDGE_CLK_REGS_VH
`define BRIDGE_CLK_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CLK_DISABLE     8'h00
`define IDX_POWER_STATE     8'h01
`define IDX_CLK_STATUS      8'h02
`define IDX_CLK_RUN_CTRL    8'h6F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_SW_STOP_BIT    0
`define CTRL_SW_MODE_BIT    4
`define STAT_STRAP_BIT      0
`define STAT_FB_ALIVE_BIT   1
`define STAT_STOPPED_BIT    2
`define STAT_B2_BIT         3
`define STAT_UP_RUN_BIT     4
`define STAT_DN_RUN_BIT     5

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define RST_CLK_DISABLE     5'h00
`define RST_POWER_STATE     2'h0
`define RST_CLK_RUN_CTRL    2'h0
`define PSTATE_D3HOT        2'h3
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

// ----------------------------------------------------------------
// Timing counts in aclk cycles
// ----------------------------------------------------------------
`define ANNOUNCE_CYCLES     4'h4
`define CHECK_CYCLES        4'h8
`define UP_REQ_CYCLES       4'h4
`define FB_TIMEOUT_CYCLES   4'hF

`endif

//--- src/bridge_secondary_clock_control.v
// Function
// - All logic runs on primary clock; fed-back secondary clock is only monitored for activity.
// - Drive five secondary clock outputs phase-locked to the primary clock.
// - Software disables each secondary clock output by its own disable bit.
// - Support primary clock-run; low means primary clock treated as always running.
// - Secondary clock stop via secondary clock-run, governed by primary or control bit 4.
// - Strap high and D3hot: secondary bus to B2, all clocks stopped low.
// - Strap low: D3hot leaves secondary clocks running.
`timescale 1ns/100ps
`default_nettype none
`include "bridge_clk_regs.vh"

module bridge_secondary_clock_control (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address and data
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Secondary clocks
    input  wire        downstream_clock_feedback,
    output wire [4:0]  downstream_clock_outputs,
    // Clock-run pins, split into input, output and enable
    input  wire        upstream_clock_run_n_in,
    output wire        upstream_clock_run_n_out,
    output wire        upstream_clock_run_n_oe,
    input  wire        downstream_clock_run_n_in,
    output wire        downstream_clock_run_n_out,
    output wire        downstream_clock_run_n_oe,
    // Strap
    input  wire        power_clock_mgmt_strap
);

    // ------------------------------------------------------------
    // Clock-run states
    // ------------------------------------------------------------
    localparam [1:0] ST_RUN  = 2'h0;
    localparam [1:0] ST_ANN  = 2'h1;
    localparam [1:0] ST_CHK  = 2'h2;
    localparam [1:0] ST_STOP = 2'h3;
    reg  [4:0] clk_dis_ff;
    reg  [1:0] pstate_ff;
    reg  [1:0] run_ctrl_ff;
    reg  [2:0] fb_sync_ff;
    reg  [1:0] up_sync_ff;
    reg  [1:0] dn_sync_ff;
    reg  [1:0] strap_sync_ff;
    reg  [3:0] fb_cnt_ff;
    reg        phase_ff;
    reg  [4:0] clk_out_ff;
    reg  [1:0] crun_st_ff;
    reg  [1:0] nxt_crun_st;
    reg  [3:0] crun_cnt_ff;
    reg  [3:0] nxt_crun_cnt;
    reg  [3:0] up_cnt_ff;
    reg  [31:0] rd_word;
    reg        rd_hit;
    wire       fb_alive;
    wire       b2_state;
    wire       stop_req;
    wire       wr_go;
    wire       rd_go;
    wire [7:0] wr_idx;
    wire [7:0] rd_idx;
    wire       wr_hit;
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pins are foreign to aclk; only the second stage feeds logic, plus the third for feedback edges
    always @(posedge aclk) begin
        if (!aresetn) begin
            fb_sync_ff    <= 3'h0;
            up_sync_ff    <= 2'h0;
            dn_sync_ff    <= 2'h0;
            strap_sync_ff <= 2'h0;
        end else begin
            fb_sync_ff    <= {fb_sync_ff[1:0], downstream_clock_feedback};
            up_sync_ff    <= {up_sync_ff[0], upstream_clock_run_n_in};
            dn_sync_ff    <= {dn_sync_ff[0], downstream_clock_run_n_in};
            strap_sync_ff <= {strap_sync_ff[0], power_clock_mgmt_strap};
        end
    end

    // ------------------------------------------------------------
    // Secondary clock feedback monitor
    // ------------------------------------------------------------
    // Feedback edges refill a timeout; silence means loop broken
    always @(posedge aclk) begin
        if (!aresetn) begin
            fb_cnt_ff <= 4'h0;
        end else if (fb_sync_ff[2] != fb_sync_ff[1]) begin
            fb_cnt_ff <= `FB_TIMEOUT_CYCLES;
        end else if (fb_cnt_ff != 4'h0) begin
            fb_cnt_ff <= fb_cnt_ff - 4'h1;
        end
    end
    assign fb_alive = (fb_cnt_ff != 4'h0);

    // ------------------------------------------------------------
    // Secondary clock generation
    // ------------------------------------------------------------
    // B2 only when strap is high; strap low leaves clocks alone
    assign b2_state = strap_sync_ff[1] &&
                      (pstate_ff == `PSTATE_D3HOT);
    // Common phase keeps all outputs aligned to the primary clock
    always @(posedge aclk) begin
        if (!aresetn) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= ~phase_ff;
        end
    end
    // An output may only rise from low and always falls next edge,
    // so a disable lands in the low half and no runt can occur
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_clk
            always @(posedge aclk) begin
                if (!aresetn) begin
                    clk_out_ff[gi] <= 1'b0;
                end else begin
                    clk_out_ff[gi] <= ~phase_ff & ~clk_dis_ff[gi]
                                      & ~b2_state
                                      & (crun_st_ff != ST_STOP);
                end
            end
        end
    endgenerate
    assign downstream_clock_outputs = clk_out_ff;

    // ------------------------------------------------------------
    // Secondary clock-run sequencer
    // ------------------------------------------------------------
    // Stop source is software when bit 4 set, else primary clock-run;
    // while primary clock-run is held low the primary clock runs
    assign stop_req = run_ctrl_ff[1] ? run_ctrl_ff[0]
                                     : (up_sync_ff[1] && (up_cnt_ff == 4'h0));
    always @* begin
        nxt_crun_st  = crun_st_ff;
        nxt_crun_cnt = crun_cnt_ff;
        case (crun_st_ff)
            ST_RUN: begin
                if (stop_req) begin
                    nxt_crun_st  = ST_ANN;
                    nxt_crun_cnt = `ANNOUNCE_CYCLES;
                end
            end
            ST_ANN: begin
                if (crun_cnt_ff == 4'h0) begin
                    nxt_crun_st  = ST_CHK;
                    nxt_crun_cnt = `CHECK_CYCLES;
                end else begin
                    nxt_crun_cnt = crun_cnt_ff - 4'h1;
                end
            end
            ST_CHK: begin
                // A device holding the line low vetoes the stop
                if (!dn_sync_ff[1] || !stop_req) begin
                    nxt_crun_st = ST_RUN;
                end else if (crun_cnt_ff == 4'h0) begin
                    nxt_crun_st = ST_STOP;
                end else begin
                    nxt_crun_cnt = crun_cnt_ff - 4'h1;
                end
            end
            ST_STOP: begin
                if (!dn_sync_ff[1] || !stop_req) begin
                    nxt_crun_st = ST_RUN;
                end
            end
            default: begin
                nxt_crun_st = ST_RUN;
            end
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            crun_st_ff  <= ST_RUN;
            crun_cnt_ff <= 4'h0;
        end else begin
            crun_st_ff  <= nxt_crun_st;
            crun_cnt_ff <= nxt_crun_cnt;
        end
    end
    // Held low while running, driven high to announce, then released
    assign downstream_clock_run_n_out = (crun_st_ff == ST_ANN);
    assign downstream_clock_run_n_oe  = (crun_st_ff == ST_RUN) ||
                                        (crun_st_ff == ST_ANN);
    // With bit 4 clear, a wake request from the secondary bus pulls
    // primary clock-run low so the host restarts the primary clock
    always @(posedge aclk) begin
        if (!aresetn) begin
            up_cnt_ff <= 4'h0;
        end else if ((crun_st_ff == ST_STOP) && !dn_sync_ff[1] && !run_ctrl_ff[1]) begin
            up_cnt_ff <= `UP_REQ_CYCLES;
        end else if (up_cnt_ff != 4'h0) begin
            up_cnt_ff <= up_cnt_ff - 4'h1;
        end
    end
    assign upstream_clock_run_n_out = 1'b0;
    assign upstream_clock_run_n_oe  = (up_cnt_ff != 4'h0);

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Address and data taken together; one write in flight at a time
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go  = s_axi_awready;
    assign rd_go  = s_axi_arvalid && s_axi_arready;
    assign wr_idx = s_axi_awaddr[9:2];
    assign rd_idx = s_axi_araddr[9:2];
    assign wr_hit = (s_axi_awaddr[31:10] == 22'h000000) &&
                    ((wr_idx == `IDX_CLK_DISABLE) || (wr_idx == `IDX_POWER_STATE) ||
                     (wr_idx == `IDX_CLK_STATUS)  || (wr_idx == `IDX_CLK_RUN_CTRL));
    // Register writes; status is read-only and ignores writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            clk_dis_ff   <= `RST_CLK_DISABLE;
            pstate_ff    <= `RST_POWER_STATE;
            run_ctrl_ff  <= `RST_CLK_RUN_CTRL;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_RESP_OKAY;
        end else begin
            if (wr_go && s_axi_wstrb[0] && (s_axi_awaddr[31:10] == 22'h000000)) begin
                if (wr_idx == `IDX_CLK_DISABLE)
                    clk_dis_ff <= s_axi_wdata[4:0];
                if (wr_idx == `IDX_POWER_STATE)
                    pstate_ff <= s_axi_wdata[1:0];
                if (wr_idx == `IDX_CLK_RUN_CTRL)
                    run_ctrl_ff <= {s_axi_wdata[`CTRL_SW_MODE_BIT],
                                    s_axi_wdata[`CTRL_SW_STOP_BIT]};
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // Read mux
    always @* begin
        rd_word = 32'h00000000;
        rd_hit  = (s_axi_araddr[31:10] == 22'h000000);
        case (rd_idx)
            `IDX_CLK_DISABLE: rd_word[4:0] = clk_dis_ff;
            `IDX_POWER_STATE: rd_word[1:0] = pstate_ff;
            `IDX_CLK_STATUS: begin
                rd_word[`STAT_STRAP_BIT]    = strap_sync_ff[1];
                rd_word[`STAT_FB_ALIVE_BIT] = fb_alive;
                rd_word[`STAT_STOPPED_BIT]  = (crun_st_ff == ST_STOP);
                rd_word[`STAT_B2_BIT]       = b2_state;
                rd_word[`STAT_UP_RUN_BIT]   = up_sync_ff[1];
                rd_word[`STAT_DN_RUN_BIT]   = dn_sync_ff[1];
            end
            `IDX_CLK_RUN_CTRL: begin
                rd_word[`CTRL_SW_STOP_BIT] = run_ctrl_ff[0];
                rd_word[`CTRL_SW_MODE_BIT] = run_ctrl_ff[1];
            end
            default: rd_hit = 1'b0;
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `AXI_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // bridge_secondary_clock_control
`default_nettype wire
